// >>> common/sar_pkg.sv
// What this block does
// RL1: Conversion-start rising edge ends acquisition, starts conversion
// RL2: Trial DAC has eighteen binary-weighted elements
// RL3: Decide bits MSB first, halving each step
// RL4: After last trial latch code, drop busy
// RL5: Internal conversion clock times trials, not serial clock
// RL6: Straight binary code, midscale has only top bit
// RL7: Span compression maps codes to tenth..nine-tenths reference
// RL8: Above active span saturates to all ones
// RL9: Below active span saturates to all zeros
// RL10: Active input clamp sets the overvoltage flag
// RL11: Flag readable by register frame and status bits
// RL12: Flag is active low, zero means overvoltage
// RL13: Flag sticky, cleared by read once clamp off
// RL14: Result holds until next conversion completes
package sar_pkg;

  // ==========================================================
  // Converter sizes and codes
  localparam int RES_BITS = 18;
  localparam logic [17:0] CODE_ZERO = 18'h0_0000;
  localparam logic [17:0] CODE_MID = 18'h2_0000;
  localparam logic [17:0] CODE_FULL = 18'h3_ffff;

  // ==========================================================
  // Timing: one trial step of the internal conversion clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRIAL_STEP_NS = 80;
  localparam int TRIAL_STEP_CYC = (TRIAL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Serial frames
  localparam int FRAME_W = 24;
  localparam logic [4:0] DATA_FRAME_BITS = 5'd24;
  localparam logic [4:0] REG_FRAME_BITS = 5'd16;
  localparam int CFG_OV_BIT = 0;
  localparam int CFG_SPAN_BIT = 1;
  localparam logic OV_FLAG_RESET = 1'b1;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SAR_ACQ = 2'b00,
    SAR_TRIAL = 2'b01,
    SAR_LATCH = 2'b11
  } sar_state_type;

  // Conditions captured at the sampling instant
  typedef struct packed {
    logic span;
    logic over;
    logic under;
  } sar_sample_type;

  // Status bits appended to conversion data
  typedef struct packed {
    logic ov_n;
    logic span;
    logic over;
    logic under;
    logic [1:0] spare;
  } sar_status_type;

endpackage

// >>> design/sar_conv_ctrl.sv
`timescale 1ns/1ps
module sar_conv_ctrl
  import sar_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic conversion_start,
  input wire logic comp_above,
  input wire logic over_range,
  input wire logic under_range,
  input wire logic clamp_active,
  input wire logic span_compress_en,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo,
  output logic busy,
  output logic hold,
  output logic [RES_BITS-1:0] dac_code,
  output logic dac_span,
  output logic [RES_BITS-1:0] result_code,
  output logic overvoltage_flag_n
);

  // ==========================================================
  // Input synchronisers
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] async_in; // Pins from outside the clock domain
  logic [NSYNC-1:0] sync1; // First stage, read only by sync2
  logic [NSYNC-1:0] sync2; // Safe copies
  logic [NSYNC-1:0] sync3; // Delayed copies for edge finding

  assign async_in = {conversion_start, comp_above, over_range,
                     under_range, clamp_active, sck, sdi};

  // Two flops per pin, plus one for edges
  // The first stage may go metastable, so only the second stage
  // feeds logic; the third copy exists purely to find edges.
  // Reset clears all three, which matches the idle level of
  // conversion_start and sck, so no false edge follows reset.
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
        end else begin
          sync1[gi] <= async_in[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end
    end
  endgenerate

  logic s_cnv; // Synced conversion start
  logic s_comp; // Synced comparator decision
  logic s_over; // Synced over-range detector
  logic s_under; // Synced under-range detector
  logic s_clamp; // Synced clamp indicator
  logic s_sdi; // Synced serial data in
  logic cnv_rise; // Conversion start edge
  logic cnv_fall; // Frame start edge
  logic sck_fall; // Serial shift edge

  assign {s_cnv, s_comp, s_over, s_under, s_clamp} = sync2[6:2];
  assign s_sdi = sync2[0];
  assign cnv_rise = sync2[6] & ~sync3[6];
  assign cnv_fall = ~sync2[6] & sync3[6];
  assign sck_fall = ~sync2[1] & sync3[1];

  // ==========================================================
  // Internal conversion clock
  sar_state_type state; // Conversion phase
  logic [7:0] div; // Trial step divider
  logic [7:0] next_div;
  logic tick; // One-cycle trial enable

  // The divider is the conversion clock: one trial per tick.
  // It is held at zero outside trials so every conversion
  // starts with a full first step for the comparator to settle.

  assign tick = (div == 8'(TRIAL_STEP_CYC - 1));

  // Divider runs only while trials are in progress
  always_comb begin
    if (state != SAR_TRIAL) begin
      next_div = 8'h00; // RL5
    end else if (tick) begin
      next_div = 8'h00;
    end else begin
      next_div = div + 8'h01;
    end
  end

  // Divider register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div <= 8'h00;
    end else begin
      div <= next_div;
    end
  end

  // ==========================================================
  // Successive approximation controller
  sar_state_type next_state;
  logic [4:0] bit_idx; // Bit under trial
  logic [4:0] next_bit_idx;
  logic [RES_BITS-1:0] next_dac_code;
  logic [RES_BITS-1:0] next_result;
  sar_sample_type smp; // Captured span and range state
  sar_sample_type next_smp;
  logic next_busy;
  logic next_hold;

  // Phase sequencing and bit decisions
  // Each decision uses the comparator level sampled through the
  // synchroniser, which lags the trial code by two cycles; a
  // step of several cycles leaves ample margin for that lag.
  // Start edges seen outside acquisition are ignored on purpose.
  always_comb begin
    next_state = state;
    next_bit_idx = bit_idx;
    next_dac_code = dac_code;
    next_result = result_code;
    next_smp = smp;
    next_busy = busy;
    next_hold = hold;
    case (state)
      // Acquisition: wait for the start edge
      SAR_ACQ: begin
        if (cnv_rise) begin
          next_state = SAR_TRIAL; // RL1
          next_hold = 1'b1; // RL1
          next_busy = 1'b1;
          next_smp = '{span: span_compress_en, over: s_over, under: s_under};
          next_dac_code = CODE_MID; // RL3
          next_bit_idx = 5'(RES_BITS - 1); // RL2
        end
      end
      // One decision per conversion clock tick
      SAR_TRIAL: begin
        if (tick) begin
          if (!s_comp) begin
            next_dac_code[bit_idx] = 1'b0; // RL3
          end
          if (bit_idx == 5'd0) begin
            next_state = SAR_LATCH;
          end else begin
            next_bit_idx = bit_idx - 5'd1; // RL3
            next_dac_code[bit_idx - 5'd1] = 1'b1; // RL3
          end
        end
      end
      // Final code with saturation, then end of busy
      SAR_LATCH: begin
        if (smp.over) begin
          next_result = CODE_FULL; // RL8
        end else if (smp.under) begin
          next_result = CODE_ZERO; // RL9
        end else begin
          next_result = dac_code; // RL6
        end
        next_busy = 1'b0; // RL4
        next_hold = 1'b0;
        next_state = SAR_ACQ;
      end
      default: begin
        next_state = SAR_ACQ;
        next_busy = 1'b0;
        next_hold = 1'b0;
      end
    endcase
  end

  // Controller registers; result only changes in the latch phase
  // The span mode reaches the DAC as soon as it is captured and
  // stays fixed for the whole conversion.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= SAR_ACQ;
      bit_idx <= 5'd0;
      dac_code <= CODE_ZERO;
      result_code <= CODE_ZERO;
      smp <= '0;
      busy <= 1'b0;
      hold <= 1'b0;
      dac_span <= 1'b0;
    end else begin
      state <= next_state;
      bit_idx <= next_bit_idx;
      dac_code <= next_dac_code;
      result_code <= next_result; // RL14
      smp <= next_smp;
      busy <= next_busy;
      hold <= next_hold;
      dac_span <= next_smp.span; // RL7
    end
  end

  // ==========================================================
  // Serial readout
  // A falling conversion_start during acquisition opens a frame;
  // the sdi level at that moment picks the register frame or the
  // data frame. Bits leave MSB first, one per falling sck edge.
  // A rising conversion_start aborts a frame, which then does not
  // count as a read of the flag.
  logic frame_on; // Frame in progress
  logic next_frame_on;
  logic [FRAME_W-1:0] shift; // Outgoing bits, MSB first
  logic [FRAME_W-1:0] next_shift;
  logic [4:0] cnt; // Bits shifted so far
  logic [4:0] next_cnt;
  logic [4:0] flen; // Length of this frame
  logic [4:0] next_flen;
  logic read_done; // Full frame read, one cycle
  logic next_read_done;
  sar_status_type stat; // Status appended to data
  logic [7:0] cfg; // Configuration register image

  always_comb begin
    stat = '{ov_n: overvoltage_flag_n, span: smp.span, over: smp.over,
             under: smp.under, spare: 2'b00};
    cfg = 8'h00;
    cfg[CFG_OV_BIT] = overvoltage_flag_n; // RL11
    cfg[CFG_SPAN_BIT] = span_compress_en;
  end

  // Frame load, shift and completion
  // The frame ends after exactly flen falling edges; read_done
  // pulses once so that the flag logic sees a single read.
  always_comb begin
    next_frame_on = frame_on;
    next_shift = shift;
    next_cnt = cnt;
    next_flen = flen;
    next_read_done = 1'b0;
    if (cnv_rise) begin
      next_frame_on = 1'b0;
    end else if (cnv_fall && state == SAR_ACQ) begin
      next_frame_on = 1'b1;
      next_cnt = 5'd0;
      if (s_sdi) begin
        next_flen = REG_FRAME_BITS; // RL11
        next_shift = {8'h00, cfg, 8'h00};
      end else begin
        next_flen = DATA_FRAME_BITS; // RL11
        next_shift = {result_code, stat};
      end
    end else if (frame_on && sck_fall) begin
      next_shift = {shift[FRAME_W-2:0], 1'b0};
      next_cnt = cnt + 5'd1;
      if (cnt + 5'd1 == flen) begin
        next_frame_on = 1'b0;
        next_read_done = 1'b1;
      end
    end
  end

  // Serial registers
  // Sdo is zero outside frames so a released line reads low.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frame_on <= 1'b0;
      shift <= '0;
      cnt <= 5'd0;
      flen <= DATA_FRAME_BITS;
      read_done <= 1'b0;
      sdo <= 1'b0;
    end else begin
      frame_on <= next_frame_on;
      shift <= next_shift;
      cnt <= next_cnt;
      flen <= next_flen;
      read_done <= next_read_done;
      sdo <= next_frame_on & next_shift[FRAME_W-1];
    end
  end

  // ==========================================================
  // Overvoltage flag
  logic next_ov_n;

  // Sticky low; a clamp event wins over a clearing read
  // The flag clears only on a completed read with the clamp off,
  // so a host cannot miss an event that is still in progress.
  always_comb begin
    next_ov_n = overvoltage_flag_n;
    if (read_done && !s_clamp) begin
      next_ov_n = 1'b1; // RL13
    end
    if (s_clamp) begin
      next_ov_n = 1'b0; // RL10 RL12
    end
  end

  // Flag register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      overvoltage_flag_n <= OV_FLAG_RESET;
    end else begin
      overvoltage_flag_n <= next_ov_n;
    end
  end

endmodule

// >>> sim/sar_monitor.sv
`timescale 1ns/1ps
// ====
// Port checker
module sar_monitor
  import sar_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic conversion_start,
  input wire logic clamp_active,
  input wire logic span_compress_en,
  input wire logic busy,
  input wire logic hold,
  input wire logic sdo,
  input wire logic [RES_BITS-1:0] dac_code,
  input wire logic dac_span,
  input wire logic [RES_BITS-1:0] result_code,
  input wire logic overvoltage_flag_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  hold_tracks_a: assert property (busy == hold)
    else $error("hold differs from busy");
  first_trial_a: assert property ($rose(busy) |-> dac_code == CODE_MID)
    else $error("first trial is not midscale");
  conv_len_a: assert property ($rose(busy) |-> ##145 $fell(busy))
    else $error("conversion length wrong");
  result_hold_a: assert property ($changed(result_code) |-> $fell(busy))
    else $error("result changed outside latch");
  span_hold_a: assert property (busy && $past(busy) |-> $stable(dac_span))
    else $error("span mode moved in conversion");
  span_take_a: assert property ($rose(busy) |-> dac_span == $past(span_compress_en))
    else $error("span mode not captured at start");
  ov_set_a: assert property (clamp_active [*5] |-> !overvoltage_flag_n)
    else $error("clamp did not set flag");
  ov_clear_a: assert property ($rose(overvoltage_flag_n) |-> !conversion_start && !busy)
    else $error("flag cleared outside a read");
  sdo_idle_a: assert property (conversion_start [*6] |-> !sdo)
    else $error("sdo active outside frame");
endmodule

// >>> sim/sar_host.sv
`timescale 1ns/1ps
// ====
// Host and comparator model
module sar_host
  import sar_pkg::*;
(
  input wire logic clk_sys,
  input wire logic busy,
  input wire logic sdo,
  input wire logic [RES_BITS-1:0] dac_code,
  input wire logic [RES_BITS-1:0] target,
  output logic conversion_start,
  output logic sck,
  output logic sdi,
  output logic comp_above
);
  // Keep the trial bit while held input is not below it
  assign comp_above = dac_code <= target;
  // Lines at rest
  initial begin
    conversion_start = 1'b0;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // One conversion, then one frame of 16 or 24 bits
  task automatic run(input logic regf, output logic [23:0] w);
    int n;
    w = 24'h00_0000;
    n = 0;
    @(posedge clk_sys) conversion_start <= 1'b1;
    while (busy !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    // Serial clock rests while converting
    while (busy !== 1'b0 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    sdi <= regf;
    conversion_start <= 1'b0;
    repeat (8) @(posedge clk_sys);
    // 160 ns serial clock, sampled while high
    for (int i = (regf ? 15 : 23); i >= 0; i--) begin
      sck <= 1'b1;
      repeat (8) @(posedge clk_sys);
      w[i] = sdo;
      sck <= 1'b0;
      repeat (8) @(posedge clk_sys);
    end
    repeat (16) @(posedge clk_sys);
  endtask
endmodule

// >>> sim/sar_tb.sv
`timescale 1ns/1ps
// ====
// Top bench
module tb
  import sar_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic over_range = 1'b0;
  logic under_range = 1'b0;
  logic clamp_active = 1'b0;
  logic span_compress_en = 1'b0;
  logic [RES_BITS-1:0] target = CODE_ZERO;
  logic conversion_start, comp_above, sck, sdi, sdo, busy, hold, dac_span, overvoltage_flag_n;
  logic [RES_BITS-1:0] dac_code, result_code;
  logic [23:0] w;
  logic [RES_BITS-1:0] exp_q[$];
  logic [19:0] corner[6] = '{{2'h0, CODE_ZERO}, {2'h0, CODE_MID}, {2'h0, CODE_FULL},
    {2'h2, 18'h0_1234}, {2'h1, 18'h3_0000}, {2'h3, 18'h0_0055}};
  int err_total = 0;
  int num_checks = 0;
  integer seed = 15969;
  initial forever #5 clk_sys = ~clk_sys;
  sar_conv_ctrl dut (.clk_sys, .rst, .conversion_start, .comp_above, .over_range,
    .under_range, .clamp_active, .span_compress_en, .sck, .sdi, .sdo, .busy, .hold,
    .dac_code, .dac_span, .result_code, .overvoltage_flag_n);
  sar_host host (.clk_sys, .busy, .sdo, .dac_code, .target, .conversion_start, .sck,
    .sdi, .comp_above);
  // Compare and count
  task automatic check(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Verdict
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Oldest note against each latched result
  always @(negedge busy) begin
    #1;
    if (!rst && exp_q.size() > 0) check("result", 24'(exp_q.pop_front()), 24'(result_code));
  end
  // Note the result, convert, read a frame
  task automatic xfer(input logic regf, input logic ov);
    logic [17:0] r;
    r = over_range ? CODE_FULL : (under_range ? CODE_ZERO : target);
    exp_q.push_back(r);
    host.run(regf, w);
    if (regf) check("reg frame", {16'h0000, 6'h00, span_compress_en, ov}, w);
    else check("data frame", {r, ov, span_compress_en, over_range, under_range, 2'h0}, w);
    $display("test done regf %0b", regf);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) begin
      target <= 18'($random(seed));
      span_compress_en <= 1'($random(seed));
      @(posedge clk_sys);
      xfer(1'b0, 1'b1);
    end
    foreach (corner[i]) begin
      {over_range, under_range, target} <= corner[i];
      @(posedge clk_sys);
      xfer(1'b0, 1'b1);
    end
    {over_range, under_range} <= 2'h0;
    clamp_active <= 1'b1;
    repeat (8) @(posedge clk_sys);
    xfer(1'b0, 1'b0);
    xfer(1'b1, 1'b0);
    clamp_active <= 1'b0;
    @(posedge clk_sys);
    xfer(1'b1, 1'b0);
    xfer(1'b1, 1'b1);
    xfer(1'b0, 1'b1);
    end_of_test();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    end_of_test();
  end
endmodule
bind sar_conv_ctrl sar_monitor mon (.clk_sys, .rst, .conversion_start, .clamp_active,
  .span_compress_en,
  .busy, .hold, .sdo, .dac_code, .dac_span, .result_code, .overvoltage_flag_n);
